// [acdpc_top.sv]
`timescale 1ns/1ps
// Behaviour
// - Divide input clock by 1 to 8
// - Sync bits choose every or first sync
// - Accepted sync resets divider count
// - Sample on divided clock rising edge
// - Divider gives half-period high time at even ratios, restorer on or off
// - Restorer inactive below lower rate limit
// - Three-bit field selects power mode
// - Power-down by register or pin high
// - Outputs high impedance while powered down
// - Pin low returns to normal operation
// - Power-down turns off reference, bias, clock
// - Wake-up delay grows with down time
// - Standby keeps reference powered, faster wake
module acdpc_top #(
  parameter int DIV_RATIO_W = acdpc_pkg::DIV_W,
  parameter int RELOCK_CYCLES = acdpc_pkg::RELOCK_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial-port register access
  input wire acdpc_pkg::acdpc_reg_req_t reg_req,
  input wire logic [DIV_RATIO_W-1:0] div_ratio_m1,
  input wire logic in_clk_slow,
  output logic [7:0] power_mode_rdata,
  output logic [7:0] sync_ctrl_rdata,
  // External pins
  input wire logic sync_pin,
  input wire logic power_off_pin,
  // Clock and power outputs
  output logic div_clk,
  output logic sample_pulse,
  output logic restorer_active,
  output logic restorer_locked,
  output acdpc_pkg::acdpc_pwr_t pwr,
  output logic ready
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] sync_s_q, pd_s_q;
  logic sync_lvl_q, pd_lvl_q, sync_prev_q;
  logic sync_lvl_d, pd_lvl_d;

  always_comb begin
    sync_lvl_d = sync_lvl_q;
    pd_lvl_d = pd_lvl_q;
    // A change counts only once stages two and three agree
    if (sync_s_q[1] == sync_s_q[2]) sync_lvl_d = sync_s_q[2];
    if (pd_s_q[1] == pd_s_q[2]) pd_lvl_d = pd_s_q[2];
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync_s_q <= 3'h0;
      pd_s_q <= 3'h0;
      sync_lvl_q <= 1'b0;
      pd_lvl_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      sync_s_q <= {sync_s_q[1:0], sync_pin};
      pd_s_q <= {pd_s_q[1:0], power_off_pin};
      sync_lvl_q <= sync_lvl_d;
      pd_lvl_q <= pd_lvl_d;
      sync_prev_q <= sync_lvl_q;
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] pm_q, pm_d, sc_q, sc_d;
  logic armed_q, armed_d;
  logic sync_edge, sync_take;

  assign sync_edge = sync_lvl_q && !sync_prev_q;

  always_comb begin
    pm_d = pm_q;
    sc_d = sc_q;
    armed_d = armed_q;
    if (reg_req.wr && reg_req.addr == acdpc_pkg::POWER_MODE_SELECT_OFS) begin
      pm_d = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == acdpc_pkg::DIVIDER_SYNC_CONTROL_OFS) begin
      sc_d = reg_req.wdata;
      armed_d = 1'b1;
    end else if (sync_take && sc_q[acdpc_pkg::SYNC_ONCE_BIT]) begin
      armed_d = 1'b0;
    end
  end

  assign sync_take = sync_edge && sc_q[acdpc_pkg::SYNC_EN_BIT] &&
                     (!sc_q[acdpc_pkg::SYNC_ONCE_BIT] || armed_q);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pm_q <= acdpc_pkg::POWER_MODE_RST;
      sc_q <= acdpc_pkg::SYNC_CTRL_RST;
      armed_q <= 1'b0;
    end else begin
      pm_q <= pm_d;
      sc_q <= sc_d;
      armed_q <= armed_d;
    end
  end

  // ************************************************************
  // Power state machine
  // ************************************************************
  typedef enum logic [3:0] {
    ACDPC_RUN = 4'b0001,
    ACDPC_DOWN = 4'b0010,
    ACDPC_STBY = 4'b0100,
    ACDPC_WAKE = 4'b1000
  } acdpc_state_t;

  acdpc_state_t st_q, st_d;
  logic [acdpc_pkg::WAKE_W-1:0] down_q, down_d;
  logic [2:0] mode;
  logic want_down, want_stby;

  assign mode = pm_q[acdpc_pkg::PWR_MODE_LSB +: acdpc_pkg::PWR_MODE_W];
  assign want_down = pd_lvl_q || mode == acdpc_pkg::PM_POWER_DOWN;
  assign want_stby = mode == acdpc_pkg::PM_STANDBY;

  always_comb begin
    st_d = st_q;
    down_d = down_q;
    unique case (st_q)
      ACDPC_RUN: begin
        down_d = '0;
        if (want_down) st_d = ACDPC_DOWN;
        else if (want_stby) st_d = ACDPC_STBY;
      end
      ACDPC_DOWN: begin
        if (down_q != '1) down_d = down_q + 1'b1;
        if (!want_down) st_d = ACDPC_WAKE;
      end
      ACDPC_STBY: begin
        down_d = acdpc_pkg::WAKE_STBY_CYC[acdpc_pkg::WAKE_W-1:0];
        if (want_down) st_d = ACDPC_DOWN;
        else if (!want_stby) st_d = ACDPC_WAKE;
      end
      // Recovery counts down the time spent down, or the fixed standby count after standby
      ACDPC_WAKE: begin
        if (want_down) st_d = ACDPC_DOWN;
        else if (down_q == '0) st_d = ACDPC_RUN;
        else down_d = down_q - 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q <= ACDPC_RUN;
      down_q <= '0;
    end else begin
      st_q <= st_d;
      down_q <= down_d;
    end
  end

  // ************************************************************
  // Domain enables
  // ************************************************************
  acdpc_pkg::acdpc_pwr_t pwr_d;
  always_comb begin
    pwr_d.reference_on = st_q != ACDPC_DOWN;
    // Shut reference chain, bias and clock
    pwr_d.ref_buffer_on = !(st_q inside {ACDPC_DOWN, ACDPC_STBY});
    pwr_d.bias_on = !(st_q inside {ACDPC_DOWN, ACDPC_STBY});
    pwr_d.clock_on = !(st_q inside {ACDPC_DOWN, ACDPC_STBY});
    pwr_d.outputs_oe = st_q == ACDPC_RUN;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) pwr <= '0;
    else pwr <= pwr_d;
  end

  // ************************************************************
  // Divider and duty-cycle restorer
  // ************************************************************
  // Ratio one to eight
  // Divided clock to sampling and restorer
  acdpc_divider #(.DW(DIV_RATIO_W)) u_div (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(pwr_d.clock_on),
    .realign(sync_take),
    .ratio_m1(div_ratio_m1),
    .div_clk(div_clk),
    .sample_pulse(sample_pulse)
  );

  logic [DIV_RATIO_W-1:0] ratio_prev_q;
  logic [15:0] relock_q, relock_d;
  logic act_d;

  always_comb begin
    // Restorer live, divider sets half period
    act_d = pwr_d.clock_on && !in_clk_slow;
    relock_d = relock_q;
    if (!act_d || div_ratio_m1 != ratio_prev_q) begin
      relock_d = 16'(RELOCK_CYCLES);
    end else if (relock_q != '0) begin
      relock_d = relock_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      relock_q <= 16'(RELOCK_CYCLES);
      ratio_prev_q <= '0;
      restorer_active <= 1'b0;
    end else begin
      relock_q <= relock_d;
      ratio_prev_q <= div_ratio_m1;
      restorer_active <= act_d;
    end
  end

  assign restorer_locked = restorer_active && relock_q == '0;
  assign ready = st_q == ACDPC_RUN;
  assign power_mode_rdata = pm_q;
  assign sync_ctrl_rdata = sc_q;

  // ************************************************************
  // Checks
  // ************************************************************
  property p_pin_down;
    @(posedge core_clk) disable iff (!reset_n)
      pd_lvl_q |=> st_q == ACDPC_DOWN;
  endproperty
  a_pin_down: assert property (p_pin_down) else $error("pin ignored");

  property p_hiz;
    @(posedge core_clk) disable iff (!reset_n)
      st_q == ACDPC_DOWN |=> !pwr.outputs_oe && !pwr.clock_on;
  endproperty
  a_hiz: assert property (p_hiz) else $error("drivers on in down");

  property p_stby_ref;
    @(posedge core_clk) disable iff (!reset_n)
      st_q == ACDPC_STBY |=> pwr.reference_on && !pwr.bias_on;
  endproperty
  a_stby_ref: assert property (p_stby_ref) else $error("standby ref");

  property p_sync_reset;
    @(posedge core_clk) disable iff (!reset_n)
      sync_take && pwr_d.clock_on |=> !div_clk ##1 div_clk;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("no realign");

  property p_sync_off;
    @(posedge core_clk) disable iff (!reset_n)
      !sc_q[acdpc_pkg::SYNC_EN_BIT] |-> !sync_take;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync taken");

  property p_slow;
    @(posedge core_clk) disable iff (!reset_n)
      in_clk_slow |=> !restorer_active;
  endproperty
  a_slow: assert property (p_slow) else $error("restorer on slow");

  property p_wake_len;
    @(posedge core_clk) disable iff (!reset_n)
      st_q == ACDPC_DOWN ##1 st_q == ACDPC_WAKE && !want_down |=> !ready;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("instant wake");

  property p_mode_down;
    @(posedge core_clk) disable iff (!reset_n)
      mode == acdpc_pkg::PM_POWER_DOWN && st_q == ACDPC_RUN
        |=> st_q == ACDPC_DOWN;
  endproperty
  a_mode_down: assert property (p_mode_down) else $error("mode ignored");

  property p_sample_edge;
    @(posedge core_clk) disable iff (!reset_n)
      sample_pulse |-> div_clk;
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("edge");
endmodule

// [acdpc_pkg.sv]
package acdpc_pkg;
  // Register offsets (serial-port address space)
  localparam logic [9:0] POWER_MODE_SELECT_OFS = 10'h100;
  localparam logic [9:0] DIVIDER_SYNC_CONTROL_OFS = 10'h109;
  // Field positions
  localparam int PWR_MODE_LSB = 0;
  localparam int PWR_MODE_W = 3;
  localparam int SYNC_EN_BIT = 0;
  localparam int SYNC_ONCE_BIT = 1;
  // Reset values
  localparam logic [7:0] POWER_MODE_RST = 8'h00;
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  // Power-mode field codes
  localparam logic [2:0] PM_NORMAL = 3'h0;
  localparam logic [2:0] PM_POWER_DOWN = 3'h1;
  localparam logic [2:0] PM_STANDBY = 3'h2;
  // Divider limits
  localparam int DIV_MIN = 1;
  localparam int DIV_MAX = 8;
  localparam int DIV_W = 3;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int RELOCK_MAX_NS = 5000;
  localparam int RELOCK_CYC = (RELOCK_MAX_NS * CLK_MHZ) / 1000;
  localparam int WAKE_STBY_NS = 200;
  localparam int WAKE_STBY_CYC = (WAKE_STBY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_W = 16;
  localparam int DCR_MIN_MHZ = 20;

  // Register write carrier
  typedef struct packed {
    logic wr;
    logic [9:0] addr;
    logic [7:0] wdata;
  } acdpc_reg_req_t;

  // Power domain enables
  typedef struct packed {
    logic reference_on;
    logic ref_buffer_on;
    logic bias_on;
    logic clock_on;
    logic outputs_oe;
  } acdpc_pwr_t;
endpackage

// [acdpc_divider.sv]
`timescale 1ns/1ps
module acdpc_divider #(
  parameter int DW = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic realign,
  input wire logic [DW-1:0] ratio_m1,
  // Divided clock
  output logic div_clk,
  output logic sample_pulse
);
  logic [DW-1:0] cnt_q, cnt_d;
  logic clk_q, clk_d;
  logic pls_q, pls_d;
  logic [DW:0] half;

  always_comb begin
    half = ({1'b0, ratio_m1} + {{DW{1'b0}}, 1'b1}) >> 1;
    cnt_d = cnt_q;
    clk_d = clk_q;
    pls_d = 1'b0;
    if (!run || realign) begin
      // Same initial count in every aligned device
      cnt_d = '0;
      clk_d = 1'b0;
    end else begin
      if (cnt_q == ratio_m1) begin
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
      // Rising (sampling) edge at count zero, falling at mid period
      // Pulse with rise
      if (cnt_q == '0) begin
        clk_d = 1'b1;
        pls_d = 1'b1;
      end
      if ({1'b0, cnt_q} == half && ratio_m1 != '0) begin
        clk_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
      clk_q <= 1'b0;
      pls_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
      pls_q <= pls_d;
    end
  end

  assign div_clk = clk_q;
  assign sample_pulse = pls_q;
endmodule

// [acdpc_ext_src.sv]
`timescale 1ns/1ps
// ****************
// Sync and power pin source
// ****************
module acdpc_ext_src (
  // Clock
  input wire logic core_clk,
  // Bench requests
  input wire logic sync_req,
  input wire logic off_req,
  // Pins
  output logic sync_pin,
  output logic power_off_pin
);
  logic [2:0] hold_q = 3'h0;
  logic off_q = 1'b0;
  // Wide pulse so the three-flop filter sees it
  always @(posedge core_clk) begin
    if (sync_req)
      hold_q <= 3'h5;
    else if (hold_q != 3'h0)
      hold_q <= hold_q - 3'h1;
  end
  always @(posedge core_clk) begin
    off_q <= off_req;
  end
  assign sync_pin = (hold_q != 3'h0);
  assign power_off_pin = off_q;
endmodule

// [test_adc_clock_divider_power_control.sv]
`timescale 1ns/1ps
module test_adc_clock_divider_power_control;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  acdpc_pkg::acdpc_reg_req_t reg_req = '0;
  logic [2:0] div_ratio_m1 = 3'h0;
  logic in_clk_slow = 1'b0;
  logic sync_req = 1'b0;
  logic off_req = 1'b0;
  logic sync_pin, power_off_pin, div_clk, sample_pulse;
  logic restorer_active, restorer_locked, ready, div_prev;
  logic [7:0] power_mode_rdata, sync_ctrl_rdata, data;
  acdpc_pkg::acdpc_pwr_t pwr;
  int fail_count = 0;
  int checks = 0;
  int seed = 91680;
  int n, hi, c, x, t, w1, w2, ws;

  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) div_prev <= div_clk;

  acdpc_top #(.RELOCK_CYCLES(4)) i_dut (.core_clk(core_clk),
    .reset_n(reset_n), .reg_req(reg_req), .div_ratio_m1(div_ratio_m1),
    .in_clk_slow(in_clk_slow), .power_mode_rdata(power_mode_rdata),
    .sync_ctrl_rdata(sync_ctrl_rdata), .sync_pin(sync_pin),
    .power_off_pin(power_off_pin), .div_clk(div_clk),
    .sample_pulse(sample_pulse), .restorer_active(restorer_active),
    .restorer_locked(restorer_locked), .pwr(pwr), .ready(ready));
  acdpc_ext_src i_src (.core_clk(core_clk), .sync_req(sync_req),
    .off_req(off_req), .sync_pin(sync_pin),
    .power_off_pin(power_off_pin));

  // ****************
  // Helpers
  // ****************
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge core_clk) reg_req <= '{1'b1, a, d};
    @(posedge core_clk) reg_req.wr <= 1'b0;
    @(negedge core_clk);
  endtask
  // Counts cycles and high samples up to the next pulse
  task wait_pulse(output int n, output int hi);
    n = 0;
    hi = 0;
    do begin
      @(negedge core_clk);
      n++;
      hi += (div_clk === 1'b1);
    end while (sample_pulse !== 1'b1 && n < 100);
  endtask
  task wait_ready(output int n);
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  // Sync x cycles after a pulse; t is span to the second pulse
  task sync_run(input int x, output int t);
    int a, b, h;
    wait_pulse(a, h);
    repeat (x) @(negedge core_clk);
    @(posedge core_clk) sync_req <= 1'b1;
    @(posedge core_clk) sync_req <= 1'b0;
    wait_pulse(a, h);
    wait_pulse(b, h);
    t = x + 1 + a + b;
  endtask
  task pwr_cycle(input logic [2:0] m, input int hold, output int w);
    wr(acdpc_pkg::POWER_MODE_SELECT_OFS, {5'h00, m});
    repeat (hold) @(negedge core_clk);
    if (m == acdpc_pkg::PM_POWER_DOWN)
      check(pwr === '0 && ready === 1'b0, "power-down state");
    else
      check(pwr.reference_on === 1'b1 && ready === 1'b0, "standby");
    wr(acdpc_pkg::POWER_MODE_SELECT_OFS, 8'h00);
    wait_ready(w);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("mismatch at %0t: watchdog", $time);
    end_of_test;
  end

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    check(power_mode_rdata === acdpc_pkg::POWER_MODE_RST, "mode reset");
    check(sync_ctrl_rdata === acdpc_pkg::SYNC_CTRL_RST, "sync reset");
    data = $random(seed);
    data[2:0] = (data[2:0] < 3'h3) ? 3'h4 : data[2:0];
    wr(acdpc_pkg::POWER_MODE_SELECT_OFS, data);
    wr(10'h101, ~data);
    check(power_mode_rdata === data, "mode readback");
    check(sync_ctrl_rdata === 8'h00, "unmapped write");
    wr(acdpc_pkg::POWER_MODE_SELECT_OFS, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 12; i++) begin
      @(posedge core_clk) div_ratio_m1 <= (i < 8) ? i : $random(seed);
      wait_pulse(n, hi);
      wait_pulse(n, hi);
      wait_pulse(n, hi);
      check(n == div_ratio_m1 + 1, "divide period");
      if (div_ratio_m1 != 3'h0)
        check(div_clk === 1'b1 && div_prev === 1'b0, "pulse on rise");
      if (div_ratio_m1[0])
        check(hi == (div_ratio_m1 + 1) / 2, "half high time");
    end
    @(posedge core_clk) in_clk_slow <= 1'b1;
    repeat (4) @(negedge core_clk);
    check(restorer_active === 1'b0, "slow clock");
    @(posedge core_clk) in_clk_slow <= 1'b0;
    repeat (2) @(negedge core_clk);
    check(restorer_locked === 1'b0, "early lock");
    repeat (28) @(negedge core_clk);
    check(restorer_locked === 1'b1, "relock");
    $display("test divider done");
    @(posedge core_clk) div_ratio_m1 <= 3'h7;
    wr(acdpc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'h01);
    sync_run(0, c);
    x = (c % 8 == 7) ? 2 : 1;
    sync_run(x, t);
    check(t % 8 == (x + c) % 8, "sync every");
    wr(acdpc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'h03);
    sync_run(x, t);
    check(t % 8 == (x + c) % 8, "first sync");
    sync_run(x, t);
    check(t % 8 == 0, "later sync ignored");
    wr(acdpc_pkg::DIVIDER_SYNC_CONTROL_OFS, 8'h00);
    sync_run(x, t);
    check(t % 8 == 0, "sync disabled");
    $display("test sync done");
    pwr_cycle(acdpc_pkg::PM_POWER_DOWN, 20 + ($random(seed) & 7), w1);
    pwr_cycle(acdpc_pkg::PM_POWER_DOWN, 80, w2);
    check(w2 > w1, "wake grows");
    pwr_cycle(acdpc_pkg::PM_STANDBY, 80, ws);
    check(ws < w2, "standby faster");
    @(posedge core_clk) off_req <= 1'b1;
    repeat (10) @(negedge core_clk);
    check(pwr === '0 && ready === 1'b0, "pin down");
    @(posedge core_clk) off_req <= 1'b0;
    wait_ready(w1);
    @(negedge core_clk);
    check(ready === 1'b1 && pwr.outputs_oe === 1'b1, "pin wake");
    $display("test power done");
    end_of_test;
  end
endmodule
